/* rtl/fwp_pkg.sv */
// Constants for the flash write protection registers
package fwp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h06;
  localparam logic [7:0] OFF_PPROT = 8'h08;
  localparam logic [7:0] OFF_DPROT = 8'h09;
  // Status register field
  localparam int VIOL_BIT = 4;
  // Program-flash protection fields
  localparam int P_OPEN_BIT = 7;
  localparam int P_RNV_BIT = 6;
  localparam int P_HDIS_BIT = 5;
  localparam int P_HS_LSB = 3;
  localparam int P_LDIS_BIT = 2;
  localparam int P_LS_LSB = 0;
  // Data-flash protection fields
  localparam int D_OPEN_BIT = 7;
  localparam logic [7:0] D_IMPL_MASK = 8'h8f;
  // Values before the configuration load, and after a double fault
  localparam logic [7:0] P_FULL_PROT = 8'h7f;
  localparam logic [7:0] D_FULL_PROT = 8'h0f;
  localparam logic [7:0] P_RESET = P_FULL_PROT;
  localparam logic [7:0] D_RESET = D_FULL_PROT;
  // Flash locations of the configuration bytes
  localparam logic [17:0] CFG_PPROT_ADDR = 18'h3_ff0c;
  localparam logic [17:0] CFG_DPROT_ADDR = 18'h3_ff0d;
  // Program-flash ranges
  localparam logic [17:0] PF_BASE = 18'h3_4000;
  localparam logic [17:0] HI_TOP = 18'h3_ffff;
  localparam logic [17:0] HI_MIN_SIZE = 18'h0_0800;
  localparam logic [17:0] LO_BASE = 18'h3_8000;
  localparam logic [17:0] LO_MIN_SIZE = 18'h0_0400;
  // Data-flash range, protected length is (code + 1) << D_STEP_SHIFT
  localparam logic [17:0] DF_BASE = 18'h0_4400;
  localparam logic [17:0] DF_LIMIT = 18'h0_5400;
  localparam int D_STEP_SHIFT = 8;
  // Allowed scenario moves, byte [from], bit [to]
  localparam logic [7:0][7:0] SCEN_OK = {
    8'hff, 8'h5a, 8'h3c, 8'h18, 8'h08, 8'h0c, 8'h0a, 8'h0f
  };
endpackage : fwp_pkg

/* rtl/fwp_regs.sv */
// Flash write protection registers and program/erase protection check
// Notes on behaviour
// - Program protection writes to a disallowed scenario are discarded unchanged.
// - Program protection register always equals the enforced scenario.
// - Allowed moves follow the from/to scenario table; scenario 7 goes anywhere.
// - Program protection loads from configuration byte at 0x3_FF0C at reset.
// - Double fault on that load gives full program protection.
// - Program or erase of protected program flash refused, violation flag set.
// - Program flash block erase refused if any sector in it protected.
// - High disable bit 5 enables or disables the high range.
// - High size field writable only while high disable is set.
// - High range ends at 0x3_FFFF, 2 to 16 Kbytes by code.
// - Low range starts at 0x3_8000, 1 to 8 Kbytes by code.
// - Open bit 1 protects enabled ranges; open 0 protects everything else.
// - Data protection writes only raise size; open bit only 1 to 0.
// - Data open bit 1 leaves data flash unprotected, size ignored.
// - Data open bit at 7, size code at bits 3 to 0.
// - Data protection loads from configuration byte at 0x3_FF0D at reset.
// - Double fault on that load gives full data protection.
// - Program or erase of protected data flash refused, violation flag set.
// - Data flash block erase refused if any data sector protected.
// - Data range starts at 0x0_4400, length 256 bytes times code plus one.
// - Violation flag blocks commands; cleared only by writing one.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module fwp_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Configuration load from the flash reset sequence
  input wire logic cfg_load_i,
  input wire logic [7:0] cfg_pbyte_i,
  input wire logic [7:0] cfg_dbyte_i,
  input wire logic cfg_pfault_i,
  input wire logic cfg_dfault_i,
  // Program/erase check from the command sequencer
  input wire logic chk_req_i,
  input wire logic [17:0] chk_addr_i,
  input wire logic chk_block_i,
  output logic chk_done_o,
  output logic chk_ok_o,
  // Status
  output logic viol_o,
  output logic [7:0] pprot_o,
  output logic [7:0] dprot_o
);

  logic [7:0] pprot_q;
  logic [7:0] dprot_q;
  logic viol_q;
  logic [7:0] rdata_q;
  logic chk_done_q;
  logic chk_ok_q;

  // Bus decode
  logic wr_pprot;
  logic wr_dprot;
  logic wr_status;
  assign wr_pprot = wr_i && (addr_i == fwp_pkg::OFF_PPROT);
  assign wr_dprot = wr_i && (addr_i == fwp_pkg::OFF_DPROT);
  assign wr_status = wr_i && (addr_i == fwp_pkg::OFF_STATUS);

  function automatic logic [2:0] scen_of(input logic [7:0] v);
    scen_of = {v[fwp_pkg::P_OPEN_BIT], v[fwp_pkg::P_HDIS_BIT], v[fwp_pkg::P_LDIS_BIT]};
  endfunction : scen_of

  // Candidate program value: size fields are locked while their range is live
  logic [7:0] p_cand;
  logic [2:0] scen_cur;
  logic [2:0] scen_new;
  logic p_allowed;
  always_comb begin
    p_cand = pprot_q;
    p_cand[fwp_pkg::P_OPEN_BIT] = wdata_i[fwp_pkg::P_OPEN_BIT];
    p_cand[fwp_pkg::P_HDIS_BIT] = wdata_i[fwp_pkg::P_HDIS_BIT];
    p_cand[fwp_pkg::P_LDIS_BIT] = wdata_i[fwp_pkg::P_LDIS_BIT];
    if (pprot_q[fwp_pkg::P_HDIS_BIT]) begin
      p_cand[fwp_pkg::P_HS_LSB +: 2] = wdata_i[fwp_pkg::P_HS_LSB +: 2];
    end
    // Low size gated the same way
    if (pprot_q[fwp_pkg::P_LDIS_BIT]) begin
      p_cand[fwp_pkg::P_LS_LSB +: 2] = wdata_i[fwp_pkg::P_LS_LSB +: 2];
    end
  end

  assign scen_cur = scen_of(pprot_q);
  assign scen_new = scen_of(p_cand);
  assign p_allowed = fwp_pkg::SCEN_OK[scen_cur][scen_new];

  // Program protection register; reserved bit 6 only comes from the load
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pprot_q <= fwp_pkg::P_RESET;
    end else if (cfg_load_i) begin
      if (cfg_pfault_i) begin
        pprot_q <= fwp_pkg::P_FULL_PROT;
      end else begin
        pprot_q <= cfg_pbyte_i;
      end
    end else if (wr_pprot && p_allowed) begin
      pprot_q <= p_cand;
    end
  end

  // Data protection candidate: open only clears, size only rises
  logic [7:0] d_cand;
  logic [3:0] d_size_new;
  always_comb begin
    d_cand = dprot_q & fwp_pkg::D_IMPL_MASK;
    d_size_new = wdata_i[3:0];
    if (!wdata_i[fwp_pkg::D_OPEN_BIT]) begin
      d_cand[fwp_pkg::D_OPEN_BIT] = 1'b0;
    end
    if (d_size_new > dprot_q[3:0]) begin
      d_cand[3:0] = d_size_new;
    end
  end

  // Data protection register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dprot_q <= fwp_pkg::D_RESET;
    end else if (cfg_load_i) begin
      if (cfg_dfault_i) begin
        dprot_q <= fwp_pkg::D_FULL_PROT;
      end else begin
        dprot_q <= cfg_dbyte_i & fwp_pkg::D_IMPL_MASK;
      end
    end else if (wr_dprot) begin
      dprot_q <= d_cand;
    end
  end

  // high range start, 2K shifted by the size code
  logic [17:0] hi_start;
  logic [17:0] lo_end;
  logic in_hi;
  logic in_lo;
  logic in_pf;
  logic p_hit;
  assign hi_start = fwp_pkg::HI_TOP
                    - ((fwp_pkg::HI_MIN_SIZE << pprot_q[fwp_pkg::P_HS_LSB +: 2]) - 18'h1);
  // low range end, 1K shifted by the size code
  assign lo_end = fwp_pkg::LO_BASE
                  + ((fwp_pkg::LO_MIN_SIZE << pprot_q[fwp_pkg::P_LS_LSB +: 2]) - 18'h1);
  assign in_hi = !pprot_q[fwp_pkg::P_HDIS_BIT] && (chk_addr_i >= hi_start);
  assign in_lo = !pprot_q[fwp_pkg::P_LDIS_BIT] && (chk_addr_i >= fwp_pkg::LO_BASE)
                 && (chk_addr_i <= lo_end);
  assign in_pf = chk_addr_i >= fwp_pkg::PF_BASE;
  // open bit sets the sense of the ranges
  assign p_hit = pprot_q[fwp_pkg::P_OPEN_BIT] ? (in_hi || in_lo) : !(in_hi || in_lo);

  // data range length from size code
  logic [17:0] d_end;
  logic in_df;
  logic d_hit;
  assign d_end = fwp_pkg::DF_BASE
                 + (18'({14'h0, dprot_q[3:0]} + 18'h1) << fwp_pkg::D_STEP_SHIFT);
  assign in_df = (chk_addr_i >= fwp_pkg::DF_BASE) && (chk_addr_i < fwp_pkg::DF_LIMIT);
  // open data flash ignores the size
  assign d_hit = !dprot_q[fwp_pkg::D_OPEN_BIT] && (chk_addr_i < d_end);

  // Protection verdict for the requested operation
  logic p_any;
  logic refuse;
  assign p_any = scen_cur != 3'h7;
  always_comb begin
    refuse = 1'b0;
    if (in_pf) begin
      // program block erase needs all sectors open
      if (chk_block_i) begin
        refuse = p_any;
      end else begin
        refuse = p_hit;
      end
    end else if (in_df) begin
      // data block erase needs no protection
      if (chk_block_i) begin
        refuse = !dprot_q[fwp_pkg::D_OPEN_BIT];
      end else begin
        refuse = d_hit;
      end
    end
  end

  // Check answer one cycle after the request
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      chk_done_q <= 1'b0;
      chk_ok_q <= 1'b0;
    end else begin
      chk_done_q <= chk_req_i;
      chk_ok_q <= chk_req_i && !viol_q && !refuse;
    end
  end

  // Violation flag; a new violation wins over a same-cycle clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      viol_q <= 1'b0;
    end else if (chk_req_i && !viol_q && refuse) begin
      viol_q <= 1'b1;
    end else if (wr_status && wdata_i[fwp_pkg::VIOL_BIT]) begin
      viol_q <= 1'b0;
    end
  end

  // Read data, valid only the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else if (!rd_i) begin
      rdata_q <= 8'h00;
    end else if (addr_i == fwp_pkg::OFF_PPROT) begin
      rdata_q <= pprot_q;
    end else if (addr_i == fwp_pkg::OFF_DPROT) begin
      rdata_q <= dprot_q;
    end else if (addr_i == fwp_pkg::OFF_STATUS) begin
      rdata_q <= {3'h0, viol_q, 4'h0};
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Outputs straight from flops
  assign rdata_o = rdata_q;
  assign chk_done_o = chk_done_q;
  assign chk_ok_o = chk_ok_q;
  assign viol_o = viol_q;
  assign pprot_o = pprot_q;
  assign dprot_o = dprot_q;

  // Checks on the protection behaviour
  sequence s_bad_pwrite;
    wr_pprot && !p_allowed && !cfg_load_i;
  endsequence

  sequence s_refused_req;
    chk_req_i && !viol_q && refuse;
  endsequence

  sequence s_refused_answer;
    chk_done_o && !chk_ok_o && viol_q;
  endsequence

  a_pprot_bad_kept: assert property (
    @(posedge clk_i) disable iff (reset_i) s_bad_pwrite |=> $stable(pprot_q))
    else $error("illegal program protection write changed the register");

  a_scen_move_legal: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (!cfg_load_i && wr_pprot) |=> fwp_pkg::SCEN_OK[$past(scen_cur)][scen_cur])
    else $error("program protection moved to a disallowed scenario");

  a_pfault_full: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (cfg_load_i && cfg_pfault_i) |=> (pprot_q == fwp_pkg::P_FULL_PROT))
    else $error("program double fault did not give full protection");

  a_dfault_full: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (cfg_load_i && cfg_dfault_i) |=> (dprot_q == fwp_pkg::D_FULL_PROT))
    else $error("data double fault did not give full protection");

  a_dsize_no_drop: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !cfg_load_i |=> (dprot_q[3:0] >= $past(dprot_q[3:0]))
                    && !(dprot_q[7] && !$past(dprot_q[7])))
    else $error("data protection was reduced by a write");

  a_hsize_locked: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (!cfg_load_i && !pprot_q[fwp_pkg::P_HDIS_BIT]) |=> $stable(pprot_q[4:3]))
    else $error("high size changed while the high range was enabled");

  a_refuse_sets_viol: assert property (
    @(posedge clk_i) disable iff (reset_i) s_refused_req |=> s_refused_answer)
    else $error("protected request was not refused with the flag set");

  a_viol_blocks: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (chk_req_i && viol_q) |=> (chk_done_o && !chk_ok_o))
    else $error("request accepted while the violation flag was set");

  a_viol_sticky: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (viol_q && !(wr_status && wdata_i[fwp_pkg::VIOL_BIT])) |=> viol_q)
    else $error("violation flag cleared without a one written");

  a_dopen_free: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (chk_req_i && !viol_q && in_df && !chk_block_i && dprot_q[fwp_pkg::D_OPEN_BIT])
    |=> chk_ok_o)
    else $error("open data flash refused a program");

  a_pload_value: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (cfg_load_i && !cfg_pfault_i) |=> (pprot_q == $past(cfg_pbyte_i)))
    else $error("program protection did not take the configuration byte");

  a_dload_value: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (cfg_load_i && !cfg_dfault_i)
    |=> (dprot_q == ($past(cfg_dbyte_i) & fwp_pkg::D_IMPL_MASK)))
    else $error("data protection did not take the configuration byte");

  // reads show the live register, then zero
  a_rdata_pprot: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (rd_i && addr_i == fwp_pkg::OFF_PPROT) |=> (rdata_o == $past(pprot_q)))
    else $error("program protection read did not show the live register");

  a_rdata_idle: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !rd_i |=> (rdata_o == 8'h00))
    else $error("read data shown without a read strobe");

  a_pblock_refused: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (chk_req_i && chk_block_i && in_pf && scen_cur != 3'h7) |=> (chk_done_o && !chk_ok_o))
    else $error("program block erase allowed with a protected sector");

  a_dblock_refused: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (chk_req_i && chk_block_i && in_df && !dprot_q[fwp_pkg::D_OPEN_BIT])
    |=> (chk_done_o && !chk_ok_o))
    else $error("data block erase allowed with protection on");

  // full scenario refuses every program address
  a_full_scen_locks: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (chk_req_i && in_pf && scen_cur == 3'h3) |=> (chk_done_o && !chk_ok_o))
    else $error("fully protected program flash accepted an operation");

  // a written one clears the flag
  a_viol_clears: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (viol_q && wr_status && wdata_i[fwp_pkg::VIOL_BIT]) |=> !viol_q)
    else $error("violation flag survived a written one");

  // low size locked while its range is live
  a_lsize_locked: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (!cfg_load_i && !pprot_q[fwp_pkg::P_LDIS_BIT])
    |=> $stable(pprot_q[fwp_pkg::P_LS_LSB +: 2]))
    else $error("low size changed while the low range was enabled");

  // every request gets exactly one answer
  a_done_follows: assert property (
    @(posedge clk_i) disable iff (reset_i)
    1'b1 |=> (chk_done_o == $past(chk_req_i)))
    else $error("check answer did not follow its request");

endmodule : fwp_regs

`default_nettype wire

/* sim/fwp_cpu_model.sv */
// CPU-side model that drives the protection register port
`timescale 1ns/1ns
`default_nettype none

module fwp_cpu_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  // Idle bus at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One-cycle write; lines scrambled on release so stale values never help
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
  endtask : wr

  // One-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd
endmodule : fwp_cpu_model
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the flash write protection registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %0t got %h exp %h", $time, (g), (e)); end end

module tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr, wdata, rdata, pprot, dprot, rv;
  logic [7:0] cpb = 8'h00;
  logic [7:0] cdb = 8'h00;
  logic wr, rd, viol, done, ok;
  logic cld = 1'b0;
  logic cpf = 1'b0;
  logic cdf = 1'b0;
  logic creq = 1'b0;
  logic cblk = 1'b0;
  logic [17:0] caddr = 18'h0_0000;
  int n_errors = 0;
  int checked = 0;
  // Allowed target scenarios for each start scenario, one bit per target
  localparam logic [7:0] ALLOW [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};

  // 100 ns clock
  always #50 clk_i = ~clk_i;

  fwp_regs i_fwp_regs (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cfg_load_i(cld), .cfg_pbyte_i(cpb),
    .cfg_dbyte_i(cdb), .cfg_pfault_i(cpf), .cfg_dfault_i(cdf), .chk_req_i(creq),
    .chk_addr_i(caddr), .chk_block_i(cblk), .chk_done_o(done), .chk_ok_o(ok),
    .viol_o(viol), .pprot_o(pprot), .dprot_o(dprot));
  fwp_cpu_model i_fwp_cpu_model (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata));

  // scenario bits placed, reserved bit left erased
  function automatic logic [7:0] sb(input logic [2:0] s);
    return {s[2], 1'b1, s[1], 2'b00, s[0], 2'b00};
  endfunction : sb

  // a reprogrammed byte takes effect only through a fresh load
  task automatic ld(input logic [7:0] p, input logic [7:0] d, input logic [1:0] f = 2'b00);
    @(posedge clk_i);
    cld <= 1'b1;
    cpb <= p;
    cdb <= d;
    cpf <= f[1];
    cdf <= f[0];
    @(posedge clk_i);
    cld <= 1'b0;
    cpf <= 1'b0;
    cdf <= 1'b0;
    #1;
  endtask : ld

  // Program/erase check; a refusal is cleared unless asked to keep it
  task automatic chk(input logic [17:0] a, input logic b, input logic e, input logic h = 1'b0);
    @(posedge clk_i);
    creq <= 1'b1;
    caddr <= a;
    cblk <= b;
    @(posedge clk_i);
    creq <= 1'b0;
    #1;
    `CHK({done, ok, viol}, {1'b1, e, ~e})
    if (!e && !h) begin
      i_fwp_cpu_model.wr(8'h06, 8'h10);
      `CHK(viol, 1'b0)
    end
  endtask : chk

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // Watchdog so a stuck run still reports
  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    `CHK({pprot, dprot, viol, done}, {8'h7f, 8'h0f, 2'b00})
    ld(8'hff, 8'h80);
    i_fwp_cpu_model.rd(8'h08, rv);
    `CHK({rv, pprot}, 16'hffff)
    i_fwp_cpu_model.rd(8'h09, rv);
    `CHK({rv, dprot}, 16'h8080)
    // Unmapped place reads zero and leaves registers alone
    i_fwp_cpu_model.wr(8'h0a, 8'h00);
    i_fwp_cpu_model.rd(8'h0a, rv);
    `CHK({rv, pprot, dprot}, 24'h00ff80)
    // Each phrase fault falls back on its own register only
    ld(8'hff, 8'h80, 2'b11);
    `CHK({pprot, dprot}, 16'h7f0f)
    ld(8'hff, 8'h80, 2'b10);
    `CHK({pprot, dprot}, 16'h7f80)
    ld(8'hff, 8'h80, 2'b01);
    `CHK({pprot, dprot}, 16'hff0f)
    // Every start scenario against every target
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        ld(sb(f[2:0]), 8'h80);
        i_fwp_cpu_model.wr(8'h08, sb(t[2:0]));
        `CHK(pprot, ALLOW[f][t] ? sb(t[2:0]) : sb(f[2:0]))
      end
    end
    ld(8'hc4, 8'h80);
    i_fwp_cpu_model.wr(8'h08, 8'hdc);
    `CHK(pprot, 8'hc4)
    ld(8'he4, 8'h80);
    i_fwp_cpu_model.wr(8'h08, 8'hfc);
    `CHK(pprot, 8'hfc)
    // Reserved bit keeps its loaded value against a write
    i_fwp_cpu_model.wr(8'h08, 8'hbc);
    `CHK(pprot, 8'hfc)
    // Low size locked while the low range is live
    ld(8'hc0, 8'h80);
    i_fwp_cpu_model.wr(8'h08, 8'hc3);
    `CHK(pprot, 8'hc0)
    // Range edges for every size code
    for (int k = 0; k < 4; k++) begin
      ld(8'hc4 | 8'(k << 3), 8'h80);
      chk(18'h3_ffff - (18'h800 << k), 1'b0, 1'b1);
      chk(18'h3_ffff - (18'h800 << k) + 18'h1, 1'b0, 1'b0);
      ld(8'he0 | 8'(k), 8'h80);
      chk(18'h3_7fff, 1'b0, 1'b1);
      chk(18'h3_8000, 1'b0, 1'b0);
      chk(18'h3_7fff + (18'h400 << k), 1'b0, 1'b0);
      chk(18'h3_8000 + (18'h400 << k), 1'b0, 1'b1);
    end
    ld(8'h64, 8'h80);
    chk(18'h3_4000, 1'b0, 1'b0);
    chk(18'h0_1000, 1'b0, 1'b1);
    ld(8'h44, 8'h80);
    chk(18'h3_f800, 1'b0, 1'b1);
    chk(18'h3_f7ff, 1'b0, 1'b0);
    ld(8'hff, 8'h80);
    chk(18'h3_4000, 1'b1, 1'b1);
    ld(8'hc4, 8'h80);
    chk(18'h3_4000, 1'b1, 1'b0);
    // Flag blocks checks and clears only on a written one
    chk(18'h3_ffff, 1'b0, 1'b0, 1'b1);
    chk(18'h0_1000, 1'b0, 1'b0, 1'b1);
    i_fwp_cpu_model.wr(8'h06, 8'hef);
    `CHK(viol, 1'b1)
    // Flag visible in the status register
    i_fwp_cpu_model.rd(8'h06, rv);
    `CHK(rv, 8'h10)
    i_fwp_cpu_model.wr(8'h06, 8'h10);
    `CHK(viol, 1'b0)
    // Data flash range edges for every size code
    for (int k = 0; k < 16; k++) begin
      ld(8'hff, 8'(k));
      chk(18'h0_43ff + 18'(256 * (k + 1)), 1'b0, 1'b0);
      chk(18'h0_4400 + 18'(256 * (k + 1)), 1'b0, 1'b1);
    end
    chk(18'h0_43ff, 1'b0, 1'b1);
    chk(18'h0_4400, 1'b1, 1'b0);
    ld(8'hff, 8'h8f);
    chk(18'h0_4400, 1'b0, 1'b1);
    chk(18'h0_4400, 1'b1, 1'b1);
    // Data protection only grows
    ld(8'hff, 8'h85);
    i_fwp_cpu_model.wr(8'h09, 8'h83);
    `CHK(dprot, 8'h85)
    i_fwp_cpu_model.wr(8'h09, 8'h86);
    `CHK(dprot, 8'h86)
    i_fwp_cpu_model.wr(8'h09, 8'h06);
    `CHK(dprot, 8'h06)
    i_fwp_cpu_model.wr(8'h09, 8'h87);
    `CHK(dprot, 8'h07)
    i_fwp_cpu_model.wr(8'h09, 8'h78);
    i_fwp_cpu_model.rd(8'h09, rv);
    `CHK({rv, dprot}, 16'h0808)
    // Second reset mid-run returns to full protection, driven on an edge
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    `CHK({pprot, dprot, viol}, {8'h7f, 8'h0f, 1'b0})
    test_done();
  end
endmodule : tb_top
`default_nettype wire
